// ===== hdl/pctb_pkg.sv
// Shared constants and types for the phase-locked clock driver model
package pctb_pkg;
   // ==========================================================
   // Geometry
   localparam int NUM_MAIN = 5;
   localparam int PER_W = 20;
   localparam int NUM_PINS = 6;

   // ==========================================================
   // Timing: the system clock period and the lock window
   localparam longint CLK_PERIOD_PS = 25000;
   localparam longint LOCK_MIN_NS = 1000000;
   localparam longint LOCK_MAX_NS = 10000000;
   // Least time rounds up, longest time rounds down
   localparam longint LOCK_MIN_CYC = (LOCK_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam longint LOCK_MAX_CYC = (LOCK_MAX_NS * 1000) / CLK_PERIOD_PS;
   // Feedback rise may lead the reference rise by up to this many cycles plus one and still count
   localparam int ALIGN_WIN = 2;
   localparam logic [3:0] ALIGN_WIN_W = 4'h2;

   // ==========================================================
   // Reset values
   localparam logic [1:0] DIST_RST = 2'h0;
   localparam logic [5:0] PINS_RST = 6'h0;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic ref_a;
      logic ref_b;
      logic ref_sel;
      logic oe_rst_n;
      logic loop_en;
      logic fb;
   } pctb_pins_t;

   typedef struct packed {
      logic [NUM_MAIN-1:0] main_outputs;
      logic inverted_output;
      logic double_rate_out;
      logic half_rate_out;
   } pctb_clk_t;

   typedef enum logic [1:0] {
      ST_TRI = 2'b00,
      ST_BYP = 2'b01,
      ST_ACQ = 2'b10,
      ST_LOCK = 2'b11
   } pctb_state_t;
endpackage : pctb_pkg

// ===== hdl/pctb_nco.sv
// Digital oscillator that runs at twice the reference rate, phase reset on each reference rise
`timescale 1ns/10ps
module pctb_nco #(
   parameter int PER_W = pctb_pkg::PER_W
) (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic run_in,
   input wire logic ref_rise_in,
   output logic vco_out
);
   // ==========================================================
   // Period measurement and half-period generation
   logic [PER_W-1:0] per_cnt_q, per_cnt_d;
   logic [PER_W-1:0] period_q, period_d;
   logic [PER_W-1:0] phase_q, phase_d;
   logic [PER_W-1:0] quarter;
   logic vco_q, vco_d;

   always_comb begin
      per_cnt_d = per_cnt_q;
      period_d = period_q;
      phase_d = phase_q;
      vco_d = vco_q;
      // Two toggles per oscillator period, two oscillator periods per reference period
      quarter = period_q >> 2;
      if (quarter == '0) begin
         quarter = {{(PER_W-1){1'b0}}, 1'b1};
      end
      if (!run_in) begin
         per_cnt_d = '0;
         phase_d = '0;
         vco_d = 1'b0;
      end else if (ref_rise_in) begin
         // Rising edges only, so the reference duty cycle does not matter
         period_d = per_cnt_q + {{(PER_W-1){1'b0}}, 1'b1};
         per_cnt_d = '0;
         phase_d = '0;
         vco_d = 1'b1;
      end else begin
         if (per_cnt_q != '1) begin
            per_cnt_d = per_cnt_q + {{(PER_W-1){1'b0}}, 1'b1};
         end
         if (phase_q + {{(PER_W-1){1'b0}}, 1'b1} >= quarter) begin
            phase_d = '0;
            vco_d = ~vco_q;
         end else begin
            phase_d = phase_q + {{(PER_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         per_cnt_q <= '0;
         period_q <= '0;
         phase_q <= '0;
         vco_q <= 1'b0;
      end else begin
         per_cnt_q <= per_cnt_d;
         period_q <= period_d;
         phase_q <= phase_d;
         vco_q <= vco_d;
      end
   end

   assign vco_out = vco_q;
endmodule : pctb_nco

// ===== hdl/pctb_top.sv
// Clock driver core: reference selection, oscillator or bypass, distribution, 3-state and lock
`timescale 1ns/10ps
module pctb_top #(
   parameter int PER_W = pctb_pkg::PER_W,
   parameter int LOCK_MIN_CYC = int'(pctb_pkg::LOCK_MIN_CYC)
) (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire pctb_pkg::pctb_pins_t pins_in,
   output pctb_pkg::pctb_clk_t clk_out,
   output logic clk_oe_out,
   output logic lock_out
);
   // ==========================================================
   // Pin synchronisers: three stages, a change counts when stages two and three agree
   logic [pctb_pkg::NUM_PINS-1:0] raw;
   logic [pctb_pkg::NUM_PINS-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   assign raw = pins_in;

   genvar gi;
   generate
      for (gi = 0; gi < pctb_pkg::NUM_PINS; gi = gi + 1) begin : g_sync
         always_comb begin
            filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
         end
         always_ff @(posedge clock_in) begin
            if (!resetn_in) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               filt_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               filt_q[gi] <= filt_d[gi];
            end
         end
      end
   endgenerate

   pctb_pkg::pctb_pins_t pin;
   logic ref_lvl;
   assign pin = pctb_pkg::pctb_pins_t'(filt_q);
   assign ref_lvl = pin.ref_sel ? pin.ref_b : pin.ref_a;

   // ==========================================================
   // Edge detection and oscillator
   logic ref_prev_q, fb_prev_q, vco_prev_q;
   logic ref_rise, fb_rise, vco_fall, vco, vco_src, run, restart;
   assign ref_rise = ref_lvl & ~ref_prev_q;
   assign fb_rise = pin.fb & ~fb_prev_q;
   // Outputs 3-stated break the feedback path, so the oscillator is held with them
   assign run = pin.loop_en & pin.oe_rst_n;

   pctb_nco #(.PER_W(PER_W)) u_nco (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .run_in(run),
      .ref_rise_in(restart),
      .vco_out(vco)
   );

   // Bypass gates the reference straight into distribution
   assign vco_src = pin.loop_en ? vco : ref_lvl;
   assign vco_fall = vco_prev_q & ~vco_src;

   // ==========================================================
   // Distribution and lock tracking
   logic [1:0] dist_q, dist_d;
   logic started_q, started_d;
   logic [3:0] fb_age_q, fb_age_d;
   logic [31:0] lock_cnt_q, lock_cnt_d;
   pctb_pkg::pctb_state_t state_q, state_d;
   pctb_pkg::pctb_clk_t clk_d;
   logic oe_d, lock_d, aligned;

   always_comb begin
      dist_d = dist_q;
      started_d = started_q;
      fb_age_d = fb_age_q;
      lock_cnt_d = lock_cnt_q;
      state_d = state_q;
      aligned = fb_rise || (fb_age_q <= pctb_pkg::ALIGN_WIN_W);
      if (fb_rise) begin
         fb_age_d = 4'h0;
      end else if (fb_age_q != 4'hF) begin
         fb_age_d = fb_age_q + 4'h1;
      end
      if (!pin.oe_rst_n) begin
         // Distribution held in reset while the outputs float
         dist_d = pctb_pkg::DIST_RST;
         started_d = 1'b0;
      end else if (vco_fall) begin
         dist_d = dist_q + 2'h1;
         started_d = 1'b1;
      end
      case (state_q)
         pctb_pkg::ST_TRI: begin
            lock_cnt_d = '0;
            if (pin.oe_rst_n) begin
               state_d = pin.loop_en ? pctb_pkg::ST_ACQ : pctb_pkg::ST_BYP;
            end
         end
         pctb_pkg::ST_BYP: begin
            lock_cnt_d = '0;
            if (!pin.oe_rst_n) begin
               state_d = pctb_pkg::ST_TRI;
            end else if (pin.loop_en) begin
               state_d = pctb_pkg::ST_ACQ;
            end
         end
         pctb_pkg::ST_ACQ: begin
            if (!pin.oe_rst_n) begin
               state_d = pctb_pkg::ST_TRI;
            end else if (!pin.loop_en) begin
               state_d = pctb_pkg::ST_BYP;
            end else if (ref_rise && !aligned) begin
               lock_cnt_d = '0;
            end else if (lock_cnt_q + 32'h1 >= 32'(LOCK_MIN_CYC)) begin
               // Alignment held for the least lock time; well inside the longest
               state_d = pctb_pkg::ST_LOCK;
            end else begin
               lock_cnt_d = lock_cnt_q + 32'h1;
            end
         end
         pctb_pkg::ST_LOCK: begin
            if (!pin.oe_rst_n) begin
               state_d = pctb_pkg::ST_TRI;
            end else if (!pin.loop_en) begin
               state_d = pctb_pkg::ST_BYP;
            end else if (ref_rise && !aligned) begin
               lock_cnt_d = '0;
               state_d = pctb_pkg::ST_ACQ;
            end
         end
         default: begin
            state_d = pctb_pkg::ST_TRI;
         end
      endcase

      clk_d.main_outputs = {pctb_pkg::NUM_MAIN{dist_d[0]}};
      clk_d.inverted_output = started_d & ~dist_d[0];
      clk_d.half_rate_out = dist_d[1];
      clk_d.double_rate_out = ~vco_src;
      oe_d = pin.oe_rst_n;
      lock_d = (state_d == pctb_pkg::ST_LOCK);
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         ref_prev_q <= 1'b0;
         fb_prev_q <= 1'b0;
         vco_prev_q <= 1'b0;
         dist_q <= pctb_pkg::DIST_RST;
         started_q <= 1'b0;
         fb_age_q <= 4'hF;
         lock_cnt_q <= '0;
         state_q <= pctb_pkg::ST_TRI;
         clk_out <= '0;
         clk_oe_out <= 1'b0;
         lock_out <= 1'b0;
      end else begin
         ref_prev_q <= ref_lvl;
         fb_prev_q <= pin.fb;
         vco_prev_q <= vco_src;
         dist_q <= dist_d;
         started_q <= started_d;
         fb_age_q <= fb_age_d;
         lock_cnt_q <= lock_cnt_d;
         state_q <= state_d;
         clk_out <= clk_d;
         clk_oe_out <= oe_d;
         lock_out <= lock_d;
      end
   end

   // ==========================================================
   // Phase alignment: the oscillator restart trails each reference rise by a slip count
   // The path from oscillator to feedback pin is several cycles long; restarting right on
   // the reference rise would leave the feedback late forever and the loop would never lock.
   logic [PER_W-1:0] since_q, since_d;
   logic [PER_W-1:0] ref_per_q, ref_per_d;
   logic [PER_W-1:0] skew_q, skew_d;

   always_comb begin
      since_d = since_q;
      ref_per_d = ref_per_q;
      skew_d = skew_q;
      if (ref_rise) begin
         since_d = '0;
         ref_per_d = since_q + {{(PER_W-1){1'b0}}, 1'b1};
         if (run && !aligned) begin
            // One cycle of slip per reference period until the feedback lands in the window
            if (skew_q + {{(PER_W-1){1'b0}}, 1'b1} >= ref_per_q) begin
               skew_d = '0;
            end else begin
               skew_d = skew_q + {{(PER_W-1){1'b0}}, 1'b1};
            end
         end
      end else if (since_q != '1) begin
         since_d = since_q + {{(PER_W-1){1'b0}}, 1'b1};
      end
   end

   // Zero slip restarts on the rise itself; the guard stops a saturated count from firing
   assign restart = ref_rise ? (skew_q == '0)
      : ((skew_q != '0) && (since_q + {{(PER_W-1){1'b0}}, 1'b1} == skew_q));

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         since_q <= '1;
         ref_per_q <= '0;
         skew_q <= '0;
      end else begin
         since_q <= since_d;
         ref_per_q <= ref_per_d;
         skew_q <= skew_d;
      end
   end
endmodule : pctb_top

// ===== verif/pctb_top_asserts.sv
// Assertion checker for the clock driver core
`timescale 1ns/10ps
module pctb_asserts #(
   parameter int LOCK_MIN_CYC = int'(pctb_pkg::LOCK_MIN_CYC)
) (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire pctb_pkg::pctb_pins_t pins_in,
   input wire pctb_pkg::pctb_clk_t clk_out,
   input wire logic clk_oe_out,
   input wire logic lock_out
);
   // ====
   // Cycles the loop has been enabled and driving; lock may not come sooner
   int run_q;
   int run_d;
   logic sel_ref;
   always_comb begin
      run_d = (pins_in.loop_en && pins_in.oe_rst_n) ? run_q + 1 : 0;
      sel_ref = pins_in.ref_sel ? pins_in.ref_b : pins_in.ref_a;
   end
   always_ff @(posedge clock_in) begin
      run_q <= resetn_in ? run_d : 0;
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   a_tri_state: assert property ((!pins_in.oe_rst_n)[*8] |-> !clk_oe_out)
      else $error("outputs driven while disabled");
   a_reset_low: assert property ($rose(clk_oe_out) && !pins_in.loop_en |->
      clk_out.main_outputs == 5'h00 && !clk_out.inverted_output && !clk_out.half_rate_out)
      else $error("outputs not reset on enable");
   a_double_inv: assert property ((clk_oe_out && !pins_in.loop_en && sel_ref)[*8] |->
      !clk_out.double_rate_out)
      else $error("double rate not inverse of reference");
   a_lock_drop: assert property ((!pins_in.oe_rst_n)[*8] |-> !lock_out)
      else $error("lock held while disabled");
   a_lock_min: assert property ($rose(lock_out) |-> run_q >= LOCK_MIN_CYC)
      else $error("lock too early");
   a_main_equal: assert property (clk_oe_out |->
      clk_out.main_outputs inside {5'h00, 5'h1F})
      else $error("main outputs differ");
   a_half_div: assert property (clk_oe_out && $past(clk_oe_out) &&
      $changed(clk_out.half_rate_out) |-> $fell(clk_out.main_outputs[0]))
      else $error("half rate edge off main fall");
   a_inv_compl: assert property (clk_oe_out && clk_out.main_outputs[0] |->
      !clk_out.inverted_output)
      else $error("inverted not complement");
   a_lock_loop: assert property ($fell(pins_in.loop_en) |-> ##[1:8] !lock_out)
      else $error("lock held with loop off");
endmodule : pctb_asserts
bind pctb_top pctb_asserts #(.LOCK_MIN_CYC(LOCK_MIN_CYC)) u_pctb_asserts (
   .clock_in(clock_in), .resetn_in(resetn_in), .pins_in(pins_in),
   .clk_out(clk_out), .clk_oe_out(clk_oe_out), .lock_out(lock_out));

// ===== verif/pctb_board.sv
// Board model: reference source and feedback wire with pull-down
`timescale 1ns/10ps
module pctb_board (
   input wire logic clock_in,
   input wire logic run_in,
   input wire logic [7:0] half_in,
   input wire pctb_pkg::pctb_clk_t clk_in,
   input wire logic oe_in,
   output logic ref_out,
   output logic fb_out
);
   // ====
   // Reference stands still while not running
   logic [7:0] cnt_q = 8'h00;
   initial ref_out = 1'b0;
   always @(posedge clock_in) begin
      if (run_in) begin
         cnt_q <= (cnt_q + 8'h01 >= half_in) ? 8'h00 : cnt_q + 8'h01;
         if (cnt_q + 8'h01 >= half_in) ref_out <= #2 ~ref_out;
      end
   end
   // Pull-down keeps feedback low while the fed-back output floats
   assign fb_out = oe_in ? clk_in.main_outputs[0] : 1'b0;
endmodule : pctb_board

// ===== verif/tb_pctb_top.sv
// Self-checking testbench for the clock driver core
`timescale 1ns/10ps
module tb_pctb_top;
   localparam int LMIN = 200;
   logic clock_in = 1'b0;
   logic resetn_in = 1'b0;
   logic ref_a = 1'b0, ref_b = 1'b1, ref_sel = 1'b1, oe = 1'b0, loop_en = 1'b0, run = 1'b0;
   logic brd_ref;
   logic fb;
   logic clk_oe;
   logic lock;
   pctb_pkg::pctb_pins_t pins;
   pctb_pkg::pctb_clk_t clk;
   int fail_count = 0;
   int cmp_count = 0;
   always #12.5 clock_in = ~clock_in;
   assign pins = {run ? brd_ref : ref_a, ref_b, ref_sel, oe, loop_en, fb};
   pctb_top #(.LOCK_MIN_CYC(LMIN)) u_pctb_top (.clock_in(clock_in), .resetn_in(resetn_in),
      .pins_in(pins), .clk_out(clk), .clk_oe_out(clk_oe), .lock_out(lock));
   pctb_board u_pctb_board (.clock_in(clock_in), .run_in(run), .half_in(8'h08),
      .clk_in(clk), .oe_in(clk_oe), .ref_out(brd_ref), .fb_out(fb));
   // ====
   // Helpers
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
      #2;
   endtask : cyc
   task automatic wait_lock(output int n);
      n = 0;
      while (lock !== 1'b1 && n < 10 * LMIN) begin
         cyc(1);
         n++;
      end
   endtask : wait_lock
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   // ====
   // Scenarios
   task automatic t_bypass;
      cyc(8);
      chk("oe", 8'h00, {7'h00, clk_oe});
      chk("lock", 8'h00, {7'h00, lock});
      oe = 1'b1;
      cyc(8);
      chk("oe", 8'h01, {7'h00, clk_oe});
      chk("outs", 8'h00, clk);
      ref_b = 1'b0;
      cyc(8);
      chk("outs", 8'hFA, clk);
      ref_b = 1'b1;
      cyc(8);
      chk("outs", 8'hF8, clk);
      ref_b = 1'b0;
      cyc(8);
      chk("outs", 8'h07, clk);
   endtask : t_bypass
   task automatic t_lock;
      int n;
      int rm;
      int rd;
      int rh;
      pctb_pkg::pctb_clk_t prev;
      ref_sel = 1'b0;
      loop_en = 1'b1;
      run = 1'b1;
      wait_lock(n);
      chk("early", 8'h01, {7'h00, n >= LMIN});
      chk("lock", 8'h01, {7'h00, lock});
      rm = 0;
      rd = 0;
      rh = 0;
      prev = clk;
      repeat (160) begin
         cyc(1);
         rm += int'(clk.main_outputs[0] && !prev.main_outputs[0]);
         rd += int'(clk.double_rate_out && !prev.double_rate_out);
         rh += int'(clk.half_rate_out && !prev.half_rate_out);
         prev = clk;
      end
      chk("main rises", 8'h0A, 8'(rm));
      chk("double rises", 8'h14, 8'(rd));
      chk("half rises", 8'h05, 8'(rh));
      oe = 1'b0;
      cyc(8);
      chk("lock", 8'h00, {7'h00, lock});
      oe = 1'b1;
      wait_lock(n);
      chk("relock", 8'h01, {7'h00, lock});
      loop_en = 1'b0;
      run = 1'b0;
      cyc(8);
      chk("lock", 8'h00, {7'h00, lock});
   endtask : t_lock
   initial begin
      cyc(2);
      resetn_in = 1'b1;
      cyc(5);
      t_bypass();
      t_lock();
      give_verdict();
   end
   initial begin
      #(25 * 30000);
      fail_count++;
      give_verdict();
   end
endmodule : tb_pctb_top
